// ### verilog/cvp_pkg.sv
// cvp_pkg: constants, types and register map for the character video pipeline.
// assumes a single 125 MHz system clock; the dot rate comes from a fractional enable.
package cvp_pkg;

    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned DOT_HZ        = 15_000_000;
    localparam int unsigned DIV_MOD       = 8;
    localparam logic [2:0]  DIV_LAST      = 3'h7;
    localparam int unsigned TAP_BIT       = 2;
    localparam int unsigned ADDR_W        = 11;
    localparam int unsigned ROW_W         = 4;
    localparam int unsigned CODE_W        = 8;
    localparam int unsigned DOT_W         = 8;
    localparam int unsigned DELAY_STAGES  = 2;

    localparam logic [31:0] ACC_STEP      = 32'h1eb851ec;

    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_STATUS    = 8'h04;
    localparam logic [7:0]  OFF_GLYPH     = 8'h08;

    localparam int unsigned CTRL_INVERT   = 0;
    localparam int unsigned CTRL_SEPSTB   = 1;
    localparam int unsigned CTRL_RFSHEN   = 2;
    localparam logic [2:0]  CTRL_RESET    = 3'h0;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    typedef struct packed {
        logic              hsync;
        logic              vsync;
        logic              activeAreaFlag;
        logic              cursorMark;
        logic [ROW_W-1:0]  dotRowAddress;
        logic [ADDR_W-1:0] refreshAddress;
    } cvp_timing_t;

    typedef struct packed {
        logic              sepStrobes;
        logic              readStrobe_n;
        logic              writeStrobe_n;
        logic              readWrite;
        logic              enable;
        logic              refreshQualifier_n;
        logic              vramSelect_n;
        logic [ADDR_W-1:0] addr;
    } cvp_cpu_t;

endpackage : cvp_pkg

// ### verilog/cvp_char_divider.sv
// cvp_char_divider: dot enable and divide-by-eight character counter.
// assumes one clock; emits one-cycle enables, the dot rate by phase accumulation.
`timescale 1ns/100ps
module cvp_char_divider
    import cvp_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    output logic            dotEn,
    output logic            charEn,
    output logic [2:0]      count,
    output logic            charClockTap
);
    logic [31:0] acc_q;
    logic [32:0] accSum;

    assign accSum = {1'b0, acc_q} + {1'b0, ACC_STEP};

    // 125 MHz / 15 MHz is not whole: accumulator carry gives the mean dot rate
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            acc_q <= 32'h0;
            dotEn <= 1'b0;
        end else begin
            acc_q <= accSum[31:0];
            dotEn <= accSum[32];
        end
    end

    // clear on seven takes effect at the next dot, so it divides by eight
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count <= 3'h0;
        end else if (dotEn) begin
            count <= (count == DIV_LAST) ? 3'h0 : count + 3'h1;
        end
    end

    assign charEn       = dotEn && (count == DIV_LAST);
    assign charClockTap = count[TAP_BIT];
endmodule : cvp_char_divider

// ### verilog/cvp_character_video_pipeline.sv
// cvp_character_video_pipeline: text-mode video datapath with axi4-lite control.
// assumes an external timing controller on clk supplying refresh/row/sync/flags,
// and video ram reads that settle within one character time.
//
// Summary of operation
// - all video timing comes from one 15 MHz dot rate.
// - dot counter clears after seven, dividing by eight.
// - one counter tap is the character clock for the timing controller.
// - without processor access, the refresh address drives the ram.
// - ram data latched after settling, held while next address applies.
// - glyph lookup uses latched code plus the 4-bit dot row.
// - dot row loaded in parallel, shifted out one dot per dot tick.
// - dots combine with horizontal and vertical sync into composite video.
// - dots forced dark outside the active area.
// - active flag and cursor delayed two character times before mixing.
// - link selects lit or dark cursor; dark cursor inverts all dots.
// - separate strobes become read/write level and enable, by link choice.
// - a processor ram select clears the delay flops.
`timescale 1ns/100ps
module cvp_character_video_pipeline
    import cvp_pkg::*;
#(
    parameter int unsigned GLYPH_DEPTH = 4096
) (
    input  wire logic                clk,
    input  wire logic                rst_n,
    // axi4-lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // timing controller and processor side
    input  wire cvp_timing_t         timing,
    input  wire cvp_cpu_t            cpu,
    output logic                     charClock_q,
    // video ram port
    output logic [ADDR_W-1:0]        ramAddr_q,
    output logic                     ramWrite_q,
    input  wire logic [CODE_W-1:0]   ramData,
    // composite video: two-bit level 0=sync 1=black 2=white
    output logic [1:0]               videoLevel_q,
    output logic                     cpuReadWrite_q,
    output logic                     cpuEnable_q
);
    initial begin
        if (GLYPH_DEPTH != (1 << (CODE_W + ROW_W)))
            $error("GLYPH_DEPTH must equal 2**(CODE_W+ROW_W)");
    end

    ////////////////////////////////////////////////////////////////////////
    logic       dotEn;
    logic       charEn;
    logic [2:0] dotCount;
    logic       tap;

    cvp_char_divider u_div (
        .clk          (clk),
        .rst_n        (rst_n),
        .dotEn        (dotEn),
        .charEn       (charEn),
        .count        (dotCount),
        .charClockTap (tap)
    );

    always_ff @(posedge clk) begin
        if (!rst_n) charClock_q <= 1'b0;
        else        charClock_q <= tap;
    end

    ////////////////////////////////////////////////////////////////////////
    // control register and glyph store
    logic [2:0]        ctrl_q;
    logic [DOT_W-1:0]  glyph_q [GLYPH_DEPTH];
    logic [11:0]       glyphIdx_q;

    logic              awHeld_q, wHeld_q;
    logic [7:0]        awAddr_q;
    logic [31:0]       wData_q;
    logic [3:0]        wStrb_q;
    logic              doWrite;
    logic              cpuSel;

    assign doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHeld_q      <= 1'b0;
            wHeld_q       <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            awAddr_q      <= 8'h0;
            wData_q       <= 32'h0;
            wStrb_q       <= 4'h0;
        end else begin
            s_axi_awready <= !awHeld_q && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready  <= !wHeld_q && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHeld_q <= 1'b0;
                wHeld_q  <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (doWrite) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_q == OFF_CTRL || awAddr_q == OFF_GLYPH) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // link settings live in ctrl; the glyph store is written as index+pattern
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q     <= CTRL_RESET;
            glyphIdx_q <= 12'h0;
        end else if (doWrite && wStrb_q[0] && awAddr_q == OFF_CTRL) begin
            ctrl_q <= wData_q[2:0];
        end else if (doWrite && awAddr_q == OFF_GLYPH && wStrb_q[1] && wStrb_q[2]) begin
            glyphIdx_q <= wData_q[23:12];
        end
    end

    always_ff @(posedge clk) begin
        if (doWrite && awAddr_q == OFF_GLYPH && wStrb_q[0]) begin
            glyph_q[wData_q[23:12]] <= wData_q[7:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= RESP_OKAY;
                case (s_axi_araddr)
                    OFF_CTRL:   s_axi_rdata <= {29'h0, ctrl_q};
                    OFF_STATUS: s_axi_rdata <= {16'h0, ramAddr_q, cpuSel, tap, dotCount};
                    OFF_GLYPH:  s_axi_rdata <= {8'h0, glyphIdx_q, 4'h0, glyph_q[glyphIdx_q]};
                    default: begin
                        s_axi_rdata <= 32'h0;
                        s_axi_rresp <= RESP_SLVERR;
                    end
                endcase
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // processor interface: pins pass two flops first
    cvp_cpu_t cpuMeta_q, cpuSync_q;
    logic     rdWr, en;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuMeta_q <= '1;
            cpuSync_q <= '1;
        end else begin
            cpuMeta_q <= cpu;
            cpuSync_q <= cpuMeta_q;
        end
    end

    always_comb begin
        if (ctrl_q[CTRL_SEPSTB]) begin
            rdWr = cpuSync_q.writeStrobe_n;
            en   = !(cpuSync_q.readStrobe_n && cpuSync_q.writeStrobe_n);
        end else begin
            rdWr = cpuSync_q.readWrite;
            en   = cpuSync_q.enable;
        end
        // with the refresh link set in ctrl, refresh cycles do not count as video ram access
        if (ctrl_q[CTRL_RFSHEN] && !cpuSync_q.refreshQualifier_n) en = 1'b0;
    end

    assign cpuSel = !cpuSync_q.vramSelect_n && en;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cpuReadWrite_q <= 1'b1;
            cpuEnable_q    <= 1'b0;
        end else begin
            cpuReadWrite_q <= rdWr;
            cpuEnable_q    <= en;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address mux: processor wins only while its select and the converted enable are both active
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ramAddr_q  <= '0;
            ramWrite_q <= 1'b0;
        end else if (cpuSel) begin
            ramAddr_q  <= cpuSync_q.addr;
            ramWrite_q <= !rdWr;
        end else begin
            ramAddr_q  <= timing.refreshAddress;
            ramWrite_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pipeline: code latch at char end, then glyph fetch, then shifter
    logic [CODE_W-1:0] code_q;
    logic [DOT_W-1:0]  rowDots_q, shift_q;
    logic [DELAY_STAGES-1:0] actDly_q, curDly_q;

    // latched at the end of the character, long after the ram settled
    always_ff @(posedge clk) begin
        if (!rst_n)      code_q <= '0;
        else if (charEn) code_q <= ramData;
    end

    always_ff @(posedge clk) begin
        if (!rst_n)      rowDots_q <= '0;
        else if (charEn) rowDots_q <= glyph_q[{code_q, timing.dotRowAddress}];
    end

    always_ff @(posedge clk) begin
        if (!rst_n)          shift_q <= '0;
        else if (charEn)     shift_q <= rowDots_q;
        else if (dotEn)      shift_q <= {shift_q[DOT_W-2:0], 1'b0};
    end

    // delay flops: two character times, cleared by a processor ram select
    always_ff @(posedge clk) begin
        if (!rst_n || cpuSel) begin
            actDly_q <= '0;
            curDly_q <= '0;
        end else if (charEn) begin
            actDly_q <= {actDly_q[DELAY_STAGES-2:0], timing.activeAreaFlag};
            curDly_q <= {curDly_q[DELAY_STAGES-2:0], timing.cursorMark};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mixer: the dark-cursor link turns the whole image negative
    logic dot, lit;
    always_comb begin
        dot = shift_q[DOT_W-1] ^ curDly_q[DELAY_STAGES-1];
        lit = (dot ^ ctrl_q[CTRL_INVERT]) && actDly_q[DELAY_STAGES-1];
    end

    always_ff @(posedge clk) begin
        if (!rst_n)                             videoLevel_q <= 2'h1;
        else if (timing.hsync || timing.vsync)  videoLevel_q <= 2'h0;
        else                                    videoLevel_q <= lit ? 2'h2 : 2'h1;
    end
endmodule : cvp_character_video_pipeline

// ### verification/cvp_monitor.sv
// cvp_monitor: port-level checks on the character video pipeline.
// assumes it is bound into cvp_character_video_pipeline and sees only its ports.
`timescale 1ns/100ps
module cvp_monitor
    import cvp_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic              s_axi_rvalid,
    input wire logic              s_axi_bvalid,
    input wire logic              s_axi_bready,
    input wire logic [1:0]        s_axi_bresp,
    input wire cvp_timing_t       timing,
    input wire cvp_cpu_t          cpu,
    input wire logic              charClock_q,
    input wire logic [ADDR_W-1:0] ramAddr_q,
    input wire logic              ramWrite_q,
    input wire logic              cpuEnable_q,
    input wire logic [1:0]        videoLevel_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // cycles since the active flag went low; saturates so it cannot wrap back
    logic [8:0] darkCnt_q;
    always_ff @(posedge clk) begin
        if (!rst_n || timing.activeAreaFlag) darkCnt_q <= 9'h0;
        else if (darkCnt_q != 9'h1ff) darkCnt_q <= darkCnt_q + 9'h1;
    end

    ////////////////////////////////////////////////////////////////////////////////
    chk_char_half: assert property (
        $rose(charClock_q) |-> charClock_q[*8] ##[24:30] $fell(charClock_q))
        else $error("character clock high phase not four dot times");
    chk_level_legal: assert property (videoLevel_q != 2'h3)
        else $error("composite level outside the three defined levels");
    chk_sync_level: assert property (timing.hsync[*3] |-> videoLevel_q == 2'h0)
        else $error("line sync not shown as sync level");
    chk_dark_outside: assert property (darkCnt_q >= 9'd300 |-> videoLevel_q != 2'h2)
        else $error("lit dot outside the active area");
    // a select only counts once the converted enable is up; refresh cycles stay out when the refresh link is set
    chk_select_dark: assert property ((!cpu.vramSelect_n && cpuEnable_q)[*8] |-> videoLevel_q != 2'h2)
        else $error("lit dot during processor ram access");
    chk_refresh_route: assert property (
        (cpu.vramSelect_n && $stable(timing.refreshAddress))[*5] |-> ramAddr_q == timing.refreshAddress)
        else $error("ram address not the refresh address while idle");
    chk_cpu_route: assert property (
        (!cpu.vramSelect_n && cpuEnable_q && $stable(cpu.addr))[*5] |-> ramAddr_q == cpu.addr)
        else $error("ram address not the processor address during access");
    chk_idle_nowrite: assert property (cpu.vramSelect_n[*5] |-> !ramWrite_q)
        else $error("ram write without processor access");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not offered one cycle after address");
    chk_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
endmodule : cvp_monitor

// ### verification/cvp_far_side.sv
// cvp_far_side: behavioural display timing controller and video ram.
// assumes the design's clock and its character clock output; 96 cells a line.
`timescale 1ns/100ps
module cvp_far_side
    import cvp_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              charClock_q,
    input  wire logic [ADDR_W-1:0] ramAddr_q,
    output cvp_timing_t            timing,
    output logic [CODE_W-1:0]      ramData
);
    logic              tap_q  = 1'b0;
    logic [6:0]        col_q  = 7'h0;
    logic [4:0]        line_q = 5'h0;
    logic [ADDR_W-1:0] ref_q  = '0;

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tap_q <= 1'b0;
            col_q <= 7'h0;
            line_q <= 5'h0;
            ref_q <= '0;
        end else begin
            tap_q <= charClock_q;
            if (charClock_q && !tap_q) begin
                ref_q <= ref_q + 11'h1;
                col_q <= (col_q == 7'd95) ? 7'h0 : col_q + 7'h1;
                if (col_q == 7'd95) line_q <= line_q + 5'h1;
            end
        end
    end
    assign timing = '{col_q >= 7'd84 && col_q < 7'd92, &line_q, col_q < 7'd80, col_q == 7'd5, line_q[3:0], ref_q};
    // odd cells hold code 1, even cells code 0, so neighbours differ
    assign ramData = {7'h0, ramAddr_q[0]};
endmodule : cvp_far_side

// ### verification/tb_character_video_pipeline.sv
// tb_character_video_pipeline: self-checking bench for the video pipeline.
// assumes cvp_far_side as timing controller and ram, cvp_monitor bound below.
`timescale 1ns/100ps
module tb_character_video_pipeline;
    import cvp_pkg::*;
    logic              clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic              s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic              s_axi_arready, s_axi_rvalid, charClock_q, ramWrite_q, cpuReadWrite_q, cpuEnable_q;
    logic [7:0]        s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0]       s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]        s_axi_wstrb = 0;
    logic [1:0]        s_axi_bresp, s_axi_rresp, videoLevel_q;
    logic [ADDR_W-1:0] ramAddr_q;
    logic [CODE_W-1:0] ramData;
    cvp_timing_t       timing;
    cvp_cpu_t          cpu = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 11'h0};
    int                errors = 0, check_count = 0, cycles = 0;

    cvp_character_video_pipeline uut (.*);
    cvp_far_side far (.*);

    always #4 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            errors++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic results;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : results

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit pa, pw, ta, tw;
        pa = 1;
        pw = 1;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (pa || pw) begin
            @(negedge clk);
            ta = pa && s_axi_awready;
            tw = pw && s_axi_wready;
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
        end
        do @(negedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        @(posedge clk);
        s_axi_bready <= 1'b0;
    endtask : axiWrite

    task automatic axiRead(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'b0;
        do @(negedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge clk);
        s_axi_rready <= 1'b0;
    endtask : axiRead

    // processor pins pass two sync flops and a register; six edges covers it,
    // then half a cycle more so registered outputs are read settled
    task automatic cpuSet(input logic sel_n, q_n, rs_n, ws_n, rw, en, input logic [10:0] a);
        @(posedge clk);
        cpu <= '{1'b0, rs_n, ws_n, rw, en, q_n, sel_n, a};
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : cpuSet

    // sample three clocks after the character start, well away from the refresh step
    task automatic checkRefresh(input string name);
        @(negedge charClock_q);
        repeat (3) @(negedge clk);
        check(name, 32'(timing.refreshAddress), 32'(ramAddr_q));
    endtask : checkRefresh

    task automatic whiteCount(output int n);
        n = 0;
        @(posedge charClock_q);
        repeat (6400) begin
            @(negedge clk);
            if (videoLevel_q === 2'h2) n++;
        end
    endtask : whiteCount

    // lit dots in one 96-cell line: codes 0/1 alternate, code 1 lights four dots
    function automatic int expWhite(input bit inv);
        return (inv ? 80 * 8 - 40 * 4 : 40 * 4) * (CLK_HZ / 1_000_000) / (DOT_HZ / 1_000_000);
    endfunction : expWhite

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [1:0]  r;
        logic [31:0] d, v;
        int          w;
        time         t;
        void'($urandom(81137));
        repeat (8) @(posedge clk);
        @(negedge clk);
        check("resetOut", 32'({6'h12, 11'h0}), 32'({videoLevel_q, charClock_q, ramWrite_q, cpuReadWrite_q, cpuEnable_q, ramAddr_q}));
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        axiRead(OFF_CTRL, d, r);
        check("ctrlReset", 32'(CTRL_RESET), d);
        v = $urandom & 32'h7;
        axiWrite(OFF_CTRL, v, 4'hf, r);
        check("ctrlWrResp", 32'(RESP_OKAY), 32'(r));
        axiRead(OFF_CTRL, d, r);
        check("ctrlBack", v, d);
        axiWrite(8'h0c, v, 4'hf, r);
        check("holeWrResp", 32'(RESP_SLVERR), 32'(r));
        axiRead(8'h0c, d, r);
        check("holeRd", 32'({RESP_SLVERR, 32'h0}), 32'({r, d}));
        v = $urandom & 32'h00fff0ff;
        axiWrite(OFF_GLYPH, v, 4'h7, r);
        axiRead(OFF_GLYPH, d, r);
        check("glyphBack", 32'({v[23:12], v[7:0]}), 32'({d[23:12], d[7:0]}));
        for (int i = 0; i < 32; i++) axiWrite(OFF_GLYPH, {8'h0, 12'(i), 4'h0, i >= 16 ? 8'h0f : 8'h00}, 4'h7, r);
        axiWrite(OFF_CTRL, 32'h0, 4'hf, r);
        @(posedge charClock_q);
        t = $time;
        @(posedge charClock_q);
        check("charPeriod", 1, 32'(($time - t) / 8 inside {66, 67}));
        for (int k = 0; k < 2; k++) begin
            axiWrite(OFF_CTRL, 32'(k), 4'hf, r);
            whiteCount(w);
            check("whiteDots", 1, 32'(w > expWhite(k) - 150 && w < expWhite(k) + 150));
        end
        axiWrite(OFF_CTRL, 32'h0, 4'hf, r);
        for (int k = 0; k < 4; k++) begin
            v = $urandom;
            if (k == 0) v[13] = 1'b1;
            cpuSet(1'b0, 1'b1, 1'b1, 1'b1, v[12], v[13], v[10:0]);
            check("nativeBus", 32'(v[13:12]), 32'({cpuEnable_q, cpuReadWrite_q}));
            // without the enable the select is not an access: refresh keeps the ram
            if (v[13]) begin
                check("cpuAddr", 32'(v[10:0]), 32'(ramAddr_q));
                check("cpuWrite", 32'(!v[12]), 32'(ramWrite_q));
            end else begin
                checkRefresh("gatedAddr");
            end
        end
        cpuSet(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 11'h0);
        checkRefresh("idleAddr");
        axiWrite(OFF_CTRL, 32'h2, 4'hf, r);
        for (int k = 0; k < 3; k++) begin
            cpuSet(1'b1, 1'b1, k != 1, k != 0, k == 0, k == 2, 11'h0);
            check("strobeBus", 32'({k != 2, k != 0}), 32'({cpuEnable_q, cpuReadWrite_q}));
        end
        axiWrite(OFF_CTRL, 32'h4, 4'hf, r);
        cpuSet(1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 11'h7ff);
        checkRefresh("qualAddr");
        results();
    end
endmodule : tb_character_video_pipeline

bind cvp_character_video_pipeline cvp_monitor mon (.*);
